// ---- verilog/rtdra_pkg.sv ----
// Purpose: Shared constants and carriers for the sensor terminal register access
// Assumes: One channel, one process-image exchange per strobe
// Notes:   Register numbers are the six-bit numbers carried in the control byte
package rtdra_pkg;

  // Control byte fields
  localparam int unsigned CB_REG_MODE_BIT = 7;
  localparam int unsigned CB_WRITE_BIT    = 6;
  localparam int unsigned CB_NUM_HI       = 5;
  localparam int unsigned CB_NUM_W        = 6;

  // Register numbers
  localparam logic [5:0] REG_FW_VERSION   = 6'h09;
  localparam logic [5:0] REG_UNLOCK_KEY   = 6'h1f;
  localparam logic [5:0] REG_FEATURE_CFG  = 6'h20;
  localparam logic [5:0] REG_USER_OFFSET  = 6'h21;
  localparam logic [5:0] REG_USER_GAIN    = 6'h22;
  localparam logic [5:0] REG_FILTER_SEL   = 6'h25;
  localparam logic [5:0] REG_LINE_RES_CAL = 6'h26;
  localparam logic [5:0] REG_USER_FIRST   = 6'h20;

  // Reset values and keys
  localparam logic [15:0] FEATURE_RST    = 16'h0040;
  localparam logic [15:0] OFFSET_RST     = 16'h0000;
  localparam logic [15:0] GAIN_RST       = 16'h0100;
  localparam logic [15:0] FILTER_RST     = 16'h0000;
  localparam logic [15:0] LINE_RES_RST   = 16'h0000;
  localparam logic [15:0] CODE_WORD_RST  = 16'h0000;
  localparam logic [15:0] UNLOCK_KEY_VAL = 16'h1235;

  // Feature register fields
  localparam int unsigned FC_SCALING_EN = 0;
  localparam int unsigned FC_WDOG_EN    = 2;
  localparam int unsigned FC_LEGACY_EN  = 4;
  localparam int unsigned FC_HUNDREDTHS = 5;

  // Scaling constants
  localparam int unsigned GAIN_FRAC_BITS = 8;
  localparam int          TENTHS_DIV     = 10;
  localparam int unsigned LEGACY_SHIFT   = 3;
  localparam int unsigned LINE_RES_PER_OHM = 32;

  // Status byte in process data mode
  localparam int unsigned SB_WDOG_BIT = 1;

  // Watchdog timing
  localparam int unsigned CLK_HZ      = 20000000;
  localparam int unsigned WDOG_MS     = 100;
  localparam int unsigned WDOG_CYCLES = CLK_HZ / 1000 * WDOG_MS;

  // Process image bytes, high data byte before low data byte
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] data_hi;
    logic [7:0] data_lo;
  } rtdra_pi_t;

endpackage

// ---- verilog/rtdra_top.sv ----
// Purpose: Register bank and byte protocol of a resistance sensor terminal channel
// Assumes: Exchange inputs are synchronous to core_clk; one strobe per exchange
// Notes:   Stored user register values take effect only on a terminal restart pulse; the code word acts at once
`timescale 1ns/1ps

module rtdra_top #(
  parameter int unsigned WDOG_LIMIT = rtdra_pkg::WDOG_CYCLES,
  parameter logic [15:0] FW_VERSION = 16'h3130  // Arbitrary two-character version
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               restart,
  input  wire logic               xchg_valid,
  input  wire rtdra_pkg::rtdra_pi_t pi_out,
  input  wire logic [15:0]        meas_value,
  output rtdra_pkg::rtdra_pi_t    pi_in,
  output logic                    wdog_trip,
  output logic [15:0]             act_feature,
  output logic [15:0]             act_filter,
  output logic [15:0]             act_line_res
);
  import rtdra_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  logic       rst_meta_q;
  logic       rst_sync_q;
  wire  logic rst_n = rst_sync_q;

  // Reset is applied at once but released only on a clock edge, so
  // no register leaves reset out of step with its neighbours
  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control byte decode

  logic [7:0]  ctrl;
  logic [15:0] wr_word;
  logic        reg_mode;
  logic        wr_req;
  logic        rd_req;
  logic [5:0]  reg_num;
  logic        unlocked;
  logic        wr_ok;

  // Only a strobed byte with bit 7 set can touch a register
  // Fields of the incoming exchange
  always_comb begin
    ctrl     = pi_out.ctrl;
    wr_word  = {pi_out.data_hi, pi_out.data_lo};
    reg_mode = xchg_valid && ctrl[CB_REG_MODE_BIT];
    wr_req   = reg_mode && ctrl[CB_WRITE_BIT];
    rd_req   = reg_mode && !ctrl[CB_WRITE_BIT];
    reg_num  = ctrl[CB_NUM_HI:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Code word and write protection

  logic [15:0] code_word_q;

  // A restart in the same cycle as a key write wins, so protection
  // is always back in force after any restart
  // Code word register, always writable, cleared on restart
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_word_q <= CODE_WORD_RST;
    end else if (ce) begin
      if (restart) begin
        code_word_q <= CODE_WORD_RST;
      end else if (wr_req && reg_num == REG_UNLOCK_KEY) begin
        code_word_q <= wr_word;
      end
    end
  end

  // Refused writes are silent: the acknowledge is still returned
  // User registers accept writes only with the key in place
  always_comb begin
    unlocked = (code_word_q == UNLOCK_KEY_VAL);
    wr_ok    = wr_req && !restart && unlocked &&
               (reg_num >= REG_USER_FIRST);
  end

  //////////////////////////////////////////////////////////////////////////
  // Stored user registers

  logic [15:0] feature_q;
  logic [15:0] offset_q;
  logic [15:0] gain_q;
  logic [15:0] filter_q;
  logic [15:0] line_res_q;

  // Readback shows the stored value, not the one in use, so a host
  // can check its writes before it restarts the terminal
  // Stored values, readable back at once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      feature_q  <= FEATURE_RST;
      offset_q   <= OFFSET_RST;
      gain_q     <= GAIN_RST;
      filter_q   <= FILTER_RST;
      line_res_q <= LINE_RES_RST;
    end else if (ce && wr_ok) begin
      unique case (reg_num)
        REG_FEATURE_CFG:  feature_q  <= wr_word;
        REG_USER_OFFSET:  offset_q   <= wr_word;
        REG_USER_GAIN:    gain_q     <= wr_word;
        REG_FILTER_SEL:   filter_q   <= wr_word;
        REG_LINE_RES_CAL: line_res_q <= wr_word;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Active configuration

  logic [15:0] act_feature_q;
  logic [15:0] act_offset_q;
  logic [15:0] act_gain_q;
  logic [15:0] act_filter_q;
  logic [15:0] act_line_res_q;

  // Holding a separate active copy keeps a half-written setup from
  // reaching the measurement path between writes
  // Values in use change only at a terminal restart
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_feature_q  <= FEATURE_RST;
      act_offset_q   <= OFFSET_RST;
      act_gain_q     <= GAIN_RST;
      act_filter_q   <= FILTER_RST;
      act_line_res_q <= LINE_RES_RST;
    end else if (ce && restart) begin
      act_feature_q  <= feature_q;
      act_offset_q   <= offset_q;
      act_gain_q     <= gain_q;
      act_filter_q   <= filter_q;
      act_line_res_q <= line_res_q;
    end
  end

  assign act_feature  = act_feature_q;
  assign act_filter   = act_filter_q;
  assign act_line_res = act_line_res_q;

  //////////////////////////////////////////////////////////////////////////
  // Measurement path

  logic signed [15:0] meas_s;
  logic signed [15:0] res_val;
  logic signed [16:0] gain_s;
  logic signed [31:0] prod;
  logic signed [31:0] scaled;
  logic        [15:0] meas_word;

  // Limitation: the scaled sum is cut to 16 bits with no saturation,
  // so extreme gain or offset values wrap around
  // Gain is an unsigned multiplier, so it is widened with a zero on top
  // Resolution, user scaling, then optional legacy format
  always_comb begin
    meas_s = signed'(meas_value);
    if (act_feature_q[FC_HUNDREDTHS]) begin
      res_val = meas_s;
    end else begin
      res_val = 16'(meas_s / 16'(TENTHS_DIV));
    end
    gain_s = signed'({1'b0, act_gain_q});
    prod   = 32'(res_val) * 32'(gain_s);
    scaled = (prod >>> GAIN_FRAC_BITS) + 32'(signed'(act_offset_q));
    if (act_feature_q[FC_SCALING_EN]) begin
      meas_word = scaled[15:0];
    end else begin
      meas_word = res_val;
    end
    if (act_feature_q[FC_LEGACY_EN]) begin
      meas_word = meas_word << LEGACY_SHIFT;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Communication watchdog

  logic [31:0] wdog_cnt_q;
  logic        wdog_trip_q;

  // An exchange in the expiry cycle wins: data did arrive in time
  // The count stops one below the limit, so the counter never wraps
  // Counts idle cycles since the last exchange
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_q  <= 32'h0000_0000;
      wdog_trip_q <= 1'b0;
    end else if (ce) begin
      if (xchg_valid || !act_feature_q[FC_WDOG_EN]) begin
        wdog_cnt_q  <= 32'h0000_0000;
        wdog_trip_q <= 1'b0;
      end else if (wdog_cnt_q >= WDOG_LIMIT - 1) begin
        wdog_trip_q <= 1'b1;
      end else begin
        wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
      end
    end
  end

  assign wdog_trip = wdog_trip_q;

  //////////////////////////////////////////////////////////////////////////
  // Register read mux

  logic [15:0] rd_word;

  // Numbers without storage, other than the version, answer zero rather than stale data
  // Unlisted register numbers read as zero
  always_comb begin
    unique case (reg_num)
      REG_FW_VERSION:   rd_word = FW_VERSION;
      REG_UNLOCK_KEY:   rd_word = code_word_q;
      REG_FEATURE_CFG:  rd_word = feature_q;
      REG_USER_OFFSET:  rd_word = offset_q;
      REG_USER_GAIN:    rd_word = gain_q;
      REG_FILTER_SEL:   rd_word = filter_q;
      REG_LINE_RES_CAL: rd_word = line_res_q;
      default:          rd_word = 16'h0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Answer to the controller

  logic [7:0]  stat_d;
  logic [15:0] data_d;

  // Write acknowledges carry a zero word; the host must ignore it
  // Status byte and input word for this exchange
  always_comb begin
    if (rd_req) begin
      stat_d = ctrl;
      data_d = rd_word;
    end else if (wr_req) begin
      stat_d = ctrl & ~(8'h01 << CB_WRITE_BIT);
      data_d = 16'h0000;
    end else begin
      stat_d = 8'h00;
      stat_d[SB_WDOG_BIT] = wdog_trip_q;
      data_d = meas_word;
    end
  end

  // The answer stands until the next taken exchange, so a slow host
  // may sample it at any later cycle
  // Answer registered on the exchange strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pi_in <= '0;
    end else if (ce && xchg_valid) begin
      pi_in.ctrl    <= stat_d;
      pi_in.data_hi <= data_d[15:8];
      pi_in.data_lo <= data_d[7:0];
    end
  end

endmodule

// ---- verif/rtdra_sva.sv ----
// Purpose: Port assertions for the register access block
// Assumes: Exchange and restart are taken only with ce high
// Notes:   Watchdog idle count kept in helper logic
`timescale 1ns/1ps
module rtdra_sva #(
  parameter int unsigned WDOG_LIMIT = 20,
  parameter logic [15:0] FW_VERSION = 16'h3130
) (
  input wire logic                 core_clk,
  input wire logic                 resetn,
  input wire logic                 ce,
  input wire logic                 restart,
  input wire logic                 xchg_valid,
  input wire rtdra_pkg::rtdra_pi_t pi_out,
  input wire rtdra_pkg::rtdra_pi_t pi_in,
  input wire logic                 wdog_trip,
  input wire logic [15:0]          act_feature,
  input wire logic [15:0]          act_filter,
  input wire logic [15:0]          act_line_res
);
  import rtdra_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic [31:0] idle_q;
  ////////////////////////////////////////////////////////////////
  // Cycles with the watchdog armed and no exchange
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) idle_q <= '0;
    else if (ce) idle_q <= (xchg_valid || !act_feature[FC_WDOG_EN]) ? '0 : idle_q + 1;
  end
  ////////////////////////////////////////////////////////////////
  // Exchange kinds
  sequence s_xchg; ce && xchg_valid; endsequence
  sequence s_rd; ce && xchg_valid && pi_out.ctrl[7:6] == 2'b10; endsequence
  sequence s_wr; ce && xchg_valid && pi_out.ctrl[7:6] == 2'b11; endsequence
  read_echo_a: assert property (s_rd |=> pi_in.ctrl == $past(pi_out.ctrl))
    else $error("read status byte is not an echo");
  write_ack_a: assert property (s_wr |=> pi_in.ctrl == ($past(pi_out.ctrl) & 8'hbf))
    else $error("write status byte wrong");
  fw_read_a: assert property (s_rd ##0 pi_out.ctrl[5:0] == REG_FW_VERSION
    |=> {pi_in.data_hi, pi_in.data_lo} == FW_VERSION) else $error("version word wrong");
  proc_status_a: assert property (s_xchg ##0 !pi_out.ctrl[7]
    |=> (pi_in.ctrl & 8'hfd) == 8'h00) else $error("process status byte wrong");
  pi_hold_a: assert property (!(ce && xchg_valid) |=> $stable(pi_in))
    else $error("input image changed without exchange");
  act_hold_a: assert property (!(ce && restart)
    |=> $stable({act_feature, act_filter, act_line_res})) else $error("config changed");
  wdog_off_a: assert property (ce && !act_feature[FC_WDOG_EN] |=> !wdog_trip)
    else $error("watchdog tripped while disabled");
  wdog_late_a: assert property (idle_q >= WDOG_LIMIT |-> wdog_trip)
    else $error("watchdog failed to trip");
  wdog_feed_a: assert property (s_xchg |=> !wdog_trip)
    else $error("watchdog not cleared by exchange");
  wdog_early_a: assert property (idle_q < WDOG_LIMIT |-> !wdog_trip)
    else $error("watchdog tripped too early");
  status_wdog_a: assert property (s_xchg ##0 !pi_out.ctrl[7]
    |=> pi_in.ctrl[SB_WDOG_BIT] == $past(wdog_trip)) else $error("status watchdog bit wrong");
endmodule
bind rtdra_top rtdra_sva #(.WDOG_LIMIT(WDOG_LIMIT), .FW_VERSION(FW_VERSION)) u_sva (
  .core_clk, .resetn, .ce, .restart, .xchg_valid, .pi_out, .pi_in, .wdog_trip,
  .act_feature, .act_filter, .act_line_res);

// ---- verif/rtdra_ctrl_model.sv ----
// Purpose: Controller model driving the process image exchange
// Assumes: One exchange per call, strobe held for one edge
// Notes:   Idle bytes show the inverse of the last request
`timescale 1ns/1ps
module rtdra_ctrl_model (
  input wire logic                 core_clk,
  input wire rtdra_pkg::rtdra_pi_t pi_in,
  output logic                     xchg_valid,
  output rtdra_pkg::rtdra_pi_t     pi_out
);
  import rtdra_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Idle at time zero
  initial begin
    xchg_valid = 1'b0;
    pi_out = '0;
  end
  // One exchange: control byte, high data byte, low data byte
  task xfer(input logic [7:0] c, input logic [15:0] w, output rtdra_pi_t rsp);
    @(posedge core_clk);
    xchg_valid <= 1'b1;
    pi_out <= {c, w[15:8], w[7:0]};
    @(posedge core_clk);
    xchg_valid <= 1'b0;
    pi_out <= ~{c, w};
    #1 rsp = pi_in;
  endtask
endmodule

// ---- verif/rtdra_tb_top.sv ----
// Purpose: Self-checking bench for the register access block
// Assumes: Watchdog limit shortened to 20 cycles
// Notes:   Exchanges go through the controller model task
`timescale 1ns/1ps
module rtdra_tb_top;
  import rtdra_pkg::*;
  localparam int unsigned WL = 20;
  localparam logic [15:0] FW = 16'h3130; // Arbitrary version characters
  logic core_clk, resetn, ce, restart, xchg_valid, wdog_trip;
  rtdra_pi_t pi_out, pi_in, r;
  logic [15:0] meas_value, act_feature, act_filter, act_line_res;
  logic [5:0] rn[5] = '{6'h20, 6'h21, 6'h22, 6'h25, 6'h26};
  logic [15:0] rv[5] = '{16'h0040, 16'h0000, 16'h0100, 16'h0000, 16'h0000};
  int fails, n_tests, i, k;
  rtdra_top #(.WDOG_LIMIT(WL), .FW_VERSION(FW)) uut (.core_clk, .resetn, .ce, .restart,
    .xchg_valid, .pi_out, .meas_value, .pi_in, .wdog_trip, .act_feature, .act_filter,
    .act_line_res);
  rtdra_ctrl_model ctl (.core_clk, .pi_in, .xchg_valid, .pi_out);
  ////////////////////////////////////////////////////////////////
  // Compare one value and count it
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register read with junk in the output word
  task rd(input logic [5:0] n, input logic [15:0] e);
    ctl.xfer({2'b10, n}, 16'hdead, r);
    chk(r, {2'b10, n, e});
  endtask
  // Register write, acknowledge has bit 6 cleared
  task wr(input logic [5:0] n, input logic [15:0] v);
    ctl.xfer({2'b11, n}, v, r);
    chk(r, {2'b10, n, 16'h0000});
  endtask
  // Process exchange with a given measurement
  task px(input logic [15:0] m, input logic [15:0] e);
    @(posedge core_clk);
    meas_value <= m;
    ctl.xfer(8'h00, 16'h0000, r);
    chk(r, {8'h00, e});
  endtask
  // Terminal restart pulse
  task rst_pulse();
    @(posedge core_clk);
    restart <= 1'b1;
    @(posedge core_clk);
    restart <= 1'b0;
    #1;
  endtask
  // Counts and verdict
  task summarize();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    resetn = 1'b0;
    ce = 1'b1;
    restart = 1'b0;
    meas_value = 16'h0000;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (rn[j]) rd(rn[j], rv[j]);
    rd(6'h09, FW);
    rd(6'h1f, 16'h0000);
    chk({8'h00, act_feature}, 24'h000040);
    $display("test reset values done");
    wr(6'h21, 16'h1111);
    wr(6'h10, 16'h2222);
    rd(6'h21, 16'h0000);
    rd(6'h10, 16'h0000);
    wr(6'h1f, 16'h1235);
    rd(6'h1f, 16'h1235);
    wr(6'h21, 16'h0005);
    wr(6'h22, 16'h0200);
    wr(6'h20, 16'h0025);
    rd(6'h20, 16'h0025);
    chk({8'h00, act_feature}, 24'h000040);
    wr(6'h1f, 16'h1234);
    wr(6'h25, 16'h0003);
    rd(6'h25, 16'h0000);
    $display("test protection done");
    rst_pulse();
    chk({8'h00, act_feature}, 24'h000025);
    rd(6'h1f, 16'h0000);
    px(16'd100, 16'h00cd);
    for (k = 0; k < 100 && wdog_trip !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk(k[23:0], 24'(WL));
    if (k == 100) summarize();
    ctl.xfer(8'h00, 16'h0000, r);
    chk({23'h0, wdog_trip}, 24'h000000);
    chk(r, 24'h0200cd);
    $display("test scaling and watchdog done");
    @(posedge core_clk);
    ce <= 1'b0;
    ctl.xfer(8'hdf, 16'h1235, r);
    chk(r, 24'h0200cd);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(6'h1f, 16'h0000);
    $display("test clock enable done");
    for (i = 0; i < 12; i++) begin
      wr(6'h1f, 16'h1235);
      wr(6'h25, i[15:0]);
      wr(6'h26, i[15:0] * 16'd32);
      wr(6'h20, (i % 2 == 1) ? 16'h0010 : 16'h0000);
      rst_pulse();
      chk({8'h00, act_filter}, {8'h00, i[15:0]});
      chk({8'h00, act_line_res}, {8'h00, i[15:0] * 16'd32});
      px(16'd1234, (i % 2 == 1) ? 16'h03d8 : 16'h007b);
    end
    $display("test filter and formats done");
    summarize();
  end
endmodule
